// file: rtl/ccu_crc16_cfg.svh
`ifndef CCU_CRC16_CFG_SVH
`define CCU_CRC16_CFG_SVH

// register byte offsets
`define CCU_OFS_RESULT 8'h04
`define CCU_OFS_DATA_LO 8'h80
`define CCU_OFS_DATA_HI 8'hFF

// field positions in the result register
`define CCU_RES_MSB 15
`define CCU_FLAG_BIT 16

// reset values
`define CCU_RESULT_RST 16'h0000
`define CCU_DATA_RST 32'h0000_0000

// reflected form of x^16 + x^12 + x^5 + 1
`define CCU_POLY_REFL 16'h8408
// software start value of a computation
`define CCU_CRC_INIT 16'hFFFF
// register content once data plus its inverted crc have passed
`define CCU_CRC_GOOD 16'hF0B8

`endif

// file: rtl/ccu_pkg.sv
package ccu_pkg;
    // running crc value
    typedef logic [15:0] ccu_crc_t;
    // one bus word
    typedef logic [31:0] ccu_word_t;
    // bus access kind decoded at setup
    typedef enum logic [1:0]
    {
        CCU_ACC_NONE = 2'h0,
        CCU_ACC_RESULT = 2'h1,
        CCU_ACC_DATA = 2'h3,
        CCU_ACC_BAD = 2'h2
    } ccu_acc_e;
endpackage

// file: rtl/ccu_byte_step.sv
`timescale 1ns/1ps
`include "ccu_crc16_cfg.svh"

// folds one byte into the crc, lsb first, when enabled
module ccu_byte_step
    import ccu_pkg::*;
(
    input wire logic enable,
    input wire logic [7:0] dataByte,
    input wire ccu_crc_t crcIn,
    output ccu_crc_t crcOut
);
    // eight reflected shift steps
    always_comb
    begin
        ccu_crc_t c;
        logic fb;
        c = crcIn;
        fb = 1'b0;
        for (int i = 0; i < 8; i++)
        begin
            fb = c[0] ^ dataByte[i];
            c = {1'b0, c[15:1]};
            if (fb)
            begin
                c = c ^ `CCU_POLY_REFL;
            end
        end
        crcOut = enable ? c : crcIn;
    end
endmodule // ccu_byte_step

// file: rtl/ccu_crc16.sv
// The APB register port was left to the implementer.
`timescale 1ns/1ps
`include "ccu_crc16_cfg.svh"

module ccu_crc16
    import ccu_pkg::*;
#(
    parameter int ADDR_W = 8
)
(
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic crcPass
);
    ccu_crc_t crcReg;
    ccu_word_t dataReg;
    ccu_acc_e accKind;
    ccu_acc_e next_accKind;
    ccu_crc_t chain [0:4];
    ccu_crc_t next_crc;
    logic setupPhase;
    logic doWrite;
    logic [7:0] addrLow;
    logic flagNow;
    ccu_word_t resultWord;
    ccu_word_t next_rdata;

    assign setupPhase = psel && !penable;
    // write takes effect at the completing access edge
    assign doWrite = psel && penable && pready && pwrite && !pslverr;
    assign addrLow = paddr[7:0];

    // address decode at setup
    always_comb
    begin
        if (addrLow == `CCU_OFS_RESULT)
        begin
            next_accKind = CCU_ACC_RESULT;
        end
        else if (addrLow >= `CCU_OFS_DATA_LO)
        begin
            next_accKind = CCU_ACC_DATA;
        end
        else
        begin
            next_accKind = CCU_ACC_BAD;
        end
    end

    // byte chain, lane 0 first; all lanes in one cycle
    assign chain[0] = crcReg;
    // lane 0: least significant byte folds first
    ccu_byte_step uStep0
    (
        .enable(pstrb[0]),
        .dataByte(pwdata[7:0]),
        .crcIn(chain[0]),
        .crcOut(chain[1])
    );
    // lane 1 sees the crc after lane 0
    ccu_byte_step uStep1
    (
        .enable(pstrb[1]),
        .dataByte(pwdata[15:8]),
        .crcIn(chain[1]),
        .crcOut(chain[2])
    );
    // lane 2
    ccu_byte_step uStep2
    (
        .enable(pstrb[2]),
        .dataByte(pwdata[23:16]),
        .crcIn(chain[2]),
        .crcOut(chain[3])
    );
    // lane 3: most significant byte folds last
    ccu_byte_step uStep3
    (
        .enable(pstrb[3]),
        .dataByte(pwdata[31:24]),
        .crcIn(chain[3]),
        .crcOut(chain[4])
    );
    assign next_crc = chain[4];

    // pass flag as software sees it, from the stored crc
    assign flagNow = (crcReg == `CCU_CRC_GOOD);

    // result word: reserved zero, flag, inverted crc
    always_comb
    begin
        resultWord = 32'h0000_0000;
        resultWord[`CCU_FLAG_BIT] = flagNow;
        resultWord[`CCU_RES_MSB:0] = ~crcReg;
    end

    // read mux by the access kind decoded at setup
    always_comb
    begin
        case (next_accKind)
            CCU_ACC_RESULT:
            begin
                next_rdata = resultWord;
            end
            CCU_ACC_DATA:
            begin
                next_rdata = dataReg;
            end
            default:
            begin
                next_rdata = 32'h0000_0000;
            end
        endcase
    end

    // access kind latched for the access phase
    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            accKind <= CCU_ACC_NONE;
        end
        else if (setupPhase)
        begin
            accKind <= next_accKind;
        end
    end

    // one wait-free access phase per transfer
    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready <= setupPhase;
            pslverr <= setupPhase && (next_accKind == CCU_ACC_BAD);
        end
    end

    // running crc: software load or data absorption
    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            crcReg <= `CCU_RESULT_RST;
        end
        else if (doWrite && accKind == CCU_ACC_RESULT)
        begin
            // flag bit 16 is not stored, so writes to it vanish
            if (pstrb[0])
            begin
                crcReg[7:0] <= pwdata[7:0];
            end
            if (pstrb[1])
            begin
                crcReg[15:8] <= pwdata[15:8];
            end
        end
        else if (doWrite && accKind == CCU_ACC_DATA)
        begin
            crcReg <= next_crc;
        end
    end

    // data port holds the last written bytes
    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            dataReg <= `CCU_DATA_RST;
        end
        else if (doWrite && accKind == CCU_ACC_DATA)
        begin
            for (int b = 0; b < 4; b++)
            begin
                if (pstrb[b])
                begin
                    dataReg[8*b +: 8] <= pwdata[8*b +: 8];
                end
            end
        end
    end

    // pass flag from the stored crc
    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            crcPass <= 1'b0;
        end
        else
        begin
            crcPass <= flagNow;
        end
    end

    // read data captured at setup, from the settled register
    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            prdata <= 32'h0000_0000;
        end
        else if (setupPhase && !pwrite)
        begin
            prdata <= next_rdata;
        end
    end
endmodule // ccu_crc16

// file: test/ccu_crc16_props.sv
`timescale 1ns/1ps
// apb port checks of the crc engine
module ccu_crc16_props
(
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    logic rdRes;
    // result read in its access cycle
    assign rdRes = pready && !pwrite && paddr == 8'h04;
    chk_ready_one: assert property (psel && !penable |=> pready) else $error("late");
    chk_ready_pulse: assert property (pready |=> !pready) else $error("long");
    chk_map_ok: assert property (pready && (paddr == 8'h04 || paddr[7]) |-> !pslverr)
        else $error("err");
    chk_unmap_err: assert property (pready && paddr != 8'h04 && !paddr[7] |-> pslverr)
        else $error("map");
    chk_res_zero: assert property (rdRes |-> prdata[31:17] == 15'h0) else $error("rsv");
    chk_flag_match: assert property (rdRes |-> prdata[16] == (prdata[15:0] == 16'h0F47))
        else $error("flag");
    chk_wr_rdback: assert property (pready && pwrite && paddr == 8'h04 && pstrb[1:0] == 2'h3
        ##2 rdRes |-> prdata[15:0] == ~$past(pwdata[15:0], 2)) else $error("inv");
    chk_rd_hold: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
        else $error("hold");
endmodule // ccu_crc16_props

// file: test/ccu_apb_master.sv
`timescale 1ns/1ps
// processor side apb master
module ccu_apb_master
(
    input wire logic ref_clk,
    input wire logic pready,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    output logic [3:0] pstrb
);
    // idle bus from time zero
    initial
    begin
        {psel, penable, pwrite, paddr, pwdata, pstrb} <= '0;
    end
    // one transfer, request held until ready
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
        input logic [3:0] s, output logic [31:0] r);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge ref_clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge ref_clk);
            n++;
        end
        while (pready !== 1'b1 && n < 16);
        r = prdata;
        tb.lastErr = pslverr;
        penable <= 1'b0;
        if (pready !== 1'b1)
        begin
            tb.failures++;
            tb.summarize();
        end
    endtask
endmodule // ccu_apb_master

// file: test/tb.sv
`timescale 1ns/1ps
module tb;
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, crcPass;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic [3:0] pstrb;
    logic [15:0] c;
    logic lastErr;
    logic [95:0] msg = 96'h0000_0000_7766_5544_3322_1100;
    int failures = 0;
    int totalChecks = 0;
    // 25 MHz clock
    always #20 ref_clk = ~ref_clk;
    ccu_crc16 ccu_crc16_i (.*);
    ccu_apb_master ccu_apb_master_i (.*);
    // compare and report
    task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
        totalChecks++;
        if (s !== e)
        begin
            failures++;
            $display("[FAIL] %s exp %h got %h", n, e, s);
        end
    endtask
    // bus accesses
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        ccu_apb_master_i.xfer(1'b1, a, d, s, r);
    endtask
    task automatic rd(input logic [7:0] a);
        ccu_apb_master_i.xfer(1'b0, a, 32'h0, 4'h0, r);
    endtask
    // reference crc, one byte lsb first
    function automatic logic [15:0] step(input logic [15:0] v, input logic [7:0] b);
        for (int i = 0; i < 8; i++)
        begin
            v = (v[0] ^ b[i]) ? (v >> 1) ^ 16'h8408 : v >> 1;
        end
        return v;
    endfunction
    task automatic summarize();
        $display("checks %0d failures %0d", totalChecks, failures);
        if (failures == 0 && totalChecks > 0)
        begin
            $display("*** PASS ***");
        end
        else
        begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // main sequence
    initial
    begin
        repeat (20) @(posedge ref_clk);
        resetn <= 1'b1;
        @(posedge ref_clk);
        rd(8'h04);
        check("res rst", r, 32'h0000_FFFF);
        check("res err", lastErr, 1'b0);
        rd(8'hC0);
        check("data rst", r, 32'h0);
        wr(8'h04, 32'h0001_1234, 4'hF);
        rd(8'h04);
        check("res wr", r, 32'h0000_EDCB);
        for (int w = 1; w <= 4; w = w * 2)
        begin
            wr(8'h04, 32'h0000_FFFF, 4'hF);
            c = 16'hFFFF;
            for (int k = 0; k < 8; k += w)
            begin
                wr(8'hFC - 8'(k * 4), msg[k * 8 +: 32], (4'h1 << w) - 4'h1);
                for (int j = 0; j < w; j++)
                begin
                    c = step(c, msg[(k + j) * 8 +: 8]);
                end
            end
            rd(8'h04);
            check("crc", r, {15'h0, c == 16'hF0B8, ~c});
        end
        wr(8'h80, {24'h0, ~c[7:0]}, 4'h1);
        wr(8'h80, {24'h0, ~c[15:8]}, 4'h1);
        rd(8'h04);
        check("pass", r[16], 1'b1);
        wr(8'h08, 32'h0000_1234, 4'hF);
        rd(8'h08);
        check("unmapped", r, 32'h0);
        check("unmapped err", lastErr, 1'b1);
        check("pass out", crcPass, 1'b1);
        summarize();
    end
endmodule // tb
bind ccu_crc16 ccu_crc16_props ccu_crc16_props_i (.*);
